// ---- hsw_pkg.sv ----
package hsw_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [5:0] HSW_ADDR_MODE_CTL  = 6'h00;
   localparam logic [5:0] HSW_ADDR_DIRECT_EN = 6'h01;
   localparam logic [5:0] HSW_ADDR_PULLUP    = 6'h02;
   localparam logic [5:0] HSW_ADDR_LOAD_TYPE = 6'h03;
   localparam logic [5:0] HSW_ADDR_SLOPE     = 6'h04;
   localparam logic [5:0] HSW_ADDR_OUT_SW    = 6'h07;

   localparam logic [7:0] HSW_RST_MODE_CTL   = 8'h00;
   localparam logic [3:0] HSW_RST_CHAN       = 4'h0;
   localparam logic [1:0] HSW_RST_LOAD_TYPE  = 2'h0;

   // -----------------------------------------------------------------
   // mode control field positions
   // -----------------------------------------------------------------
   localparam int HSW_BIT_STBY   = 5;
   localparam int HSW_BIT_UNLOCK = 4;
   localparam int HSW_BIT_TH_HI  = 2;
   localparam int HSW_BIT_TH_LO  = 1;
   localparam int HSW_BIT_EN     = 0;

   // -----------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------
   localparam int         HSW_OPC_HI      = 7;
   localparam int         HSW_OPC_LO      = 6;
   localparam logic [1:0] HSW_OPC_WRITE   = 2'h0;
   localparam logic [4:0] HSW_LEN_SHORT   = 5'h08;
   localparam logic [4:0] HSW_LEN_LONG    = 5'h10;
   localparam logic [4:0] HSW_LEN_ADDR    = 5'h07;
   localparam logic [7:0] HSW_STATUS_BYTE = 8'h00;

   // -----------------------------------------------------------------
   // case threshold codes: 120, 130, 140 degrees
   // -----------------------------------------------------------------
   localparam logic [1:0] HSW_TH_120 = 2'h0;
   localparam logic [1:0] HSW_TH_130 = 2'h1;
   localparam logic [1:0] HSW_TH_140 = 2'h2;

   typedef struct packed {
      logic       standby_request;
      logic       unlock;
      logic       case_threshold_hi;
      logic       case_threshold_lo;
      logic       enable;
   } hsw_ctl_type;

   typedef struct packed {
      logic [3:0] direct_path_enable_reg;
      logic [3:0] off_pullup_enable_reg;
      logic [1:0] load_type_reg;
      logic [3:0] slope_select_reg;
      logic [3:0] output_switch_reg;
   } hsw_chan_type;

   typedef enum logic [2:0] {
      HSW_FAILSAFE = 3'b001,
      HSW_NORMAL   = 3'b010,
      HSW_STANDBY  = 3'b100
   } hsw_mode_type;

endpackage : hsw_pkg

// ---- hsw_sync.sv ----
`timescale 1ns/100ps
module hsw_sync #(
   parameter int         WIDTH   = 1,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   // -----------------------------------------------------------------
   // two-flop synchroniser per bit
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta_ff;
         logic hold_ff;
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               meta_ff <= RST_VAL[g];
               hold_ff <= RST_VAL[g];
            end else begin
               meta_ff <= d_i[g];
               hold_ff <= meta_ff;
            end
         end
         assign q_o[g] = hold_ff;
      end
   endgenerate
endmodule : hsw_sync

// ---- hsw_output_ctrl.sv ----
`timescale 1ns/100ps
module hsw_output_ctrl
   import hsw_pkg::*;
(
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic         sck_i,
   input  wire logic         cs_n_i,
   input  wire logic         sdi_i,
   input  wire logic [3:0]   direct_input_pin_i,
   output logic              sdo_o,
   output logic              sdo_oe_n_o,
   output logic [3:0]        chan_on_o,
   output logic [1:0]        led_mode_o,
   output logic [3:0]        fast_slope_o,
   output logic [3:0]        pullup_en_o,
   output logic [1:0]        case_threshold_o,
   output hsw_mode_type      mode_o
);
   // -----------------------------------------------------------------
   // pin synchronisation
   // -----------------------------------------------------------------
   logic [6:0] pins_s;
   logic       sck_s;
   logic       cs_n_s;
   logic       sdi_s;
   logic [3:0] din_s;

   hsw_sync #(
      .WIDTH   (7),
      .RST_VAL (8'h02)
   ) u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .d_i    ({direct_input_pin_i, sdi_i, cs_n_i, sck_i}),
      .q_o    (pins_s)
   );

   assign sck_s  = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign sdi_s  = pins_s[2];
   assign din_s  = pins_s[6:3];

   // -----------------------------------------------------------------
   // serial frame engine and register bank
   // -----------------------------------------------------------------
   logic         sck_d_ff,  nxt_sck_d;
   logic         cs_d_ff,   nxt_cs_d;
   logic [15:0]  rx_ff,     nxt_rx;
   logic [4:0]   cnt_ff,    nxt_cnt;
   logic [7:0]   rd_ff,     nxt_rd;
   logic         sdo_ff,    nxt_sdo;
   logic         oe_n_ff,   nxt_oe_n;
   hsw_ctl_type  ctl_ff,    nxt_ctl;
   hsw_chan_type chan_ff,   nxt_chan;

   logic         sck_rise;
   logic         sck_fall;
   logic         frame_start;
   logic         frame_end;
   logic [5:0]   rd_addr;
   logic [7:0]   rd_mux;
   logic [7:0]   wr_data;

   assign sck_rise    = sck_s & ~sck_d_ff;
   assign sck_fall    = ~sck_s & sck_d_ff;
   assign frame_start = ~cs_n_s & cs_d_ff;
   assign frame_end   = cs_n_s & ~cs_d_ff;
   assign rd_addr     = {rx_ff[4:0], sdi_s};
   assign wr_data     = rx_ff[7:0];

   always_comb begin
      rd_mux = 8'h00;
      if (rd_addr == HSW_ADDR_MODE_CTL) begin
         rd_mux = {2'h0, ctl_ff.standby_request, ctl_ff.unlock, 1'b0,
                   ctl_ff.case_threshold_hi, ctl_ff.case_threshold_lo, ctl_ff.enable};
      end else if (rd_addr == HSW_ADDR_DIRECT_EN) begin
         rd_mux = {4'h0, chan_ff.direct_path_enable_reg};
      end else if (rd_addr == HSW_ADDR_PULLUP) begin
         rd_mux = {4'h0, chan_ff.off_pullup_enable_reg};
      end else if (rd_addr == HSW_ADDR_LOAD_TYPE) begin
         rd_mux = {6'h00, chan_ff.load_type_reg};
      end else if (rd_addr == HSW_ADDR_SLOPE) begin
         rd_mux = {4'h0, chan_ff.slope_select_reg};
      end else if (rd_addr == HSW_ADDR_OUT_SW) begin
         rd_mux = {4'h0, chan_ff.output_switch_reg};
      end
   end

   always_comb begin
      nxt_sck_d = sck_s;
      nxt_cs_d  = cs_n_s;
      nxt_rx    = rx_ff;
      nxt_cnt   = cnt_ff;
      nxt_rd    = rd_ff;
      nxt_sdo   = sdo_ff;
      nxt_oe_n  = cs_n_s;
      nxt_ctl   = ctl_ff;
      nxt_chan  = chan_ff;
      if (frame_start) begin
         nxt_cnt = 5'h00;
         nxt_rx  = 16'h0000;
         nxt_sdo = HSW_STATUS_BYTE[7];
      end else if (!cs_n_s && sck_rise) begin
         nxt_rx = {rx_ff[14:0], sdi_s};
         if (cnt_ff != 5'h1f) begin
            nxt_cnt = cnt_ff + 5'h01;
         end
         if (cnt_ff == HSW_LEN_ADDR) begin
            nxt_rd = rd_mux;
         end
      end else if (!cs_n_s && sck_fall) begin
         if (cnt_ff < HSW_LEN_SHORT) begin
            nxt_sdo = HSW_STATUS_BYTE[3'h7 - cnt_ff[2:0]];
         end else if (cnt_ff < HSW_LEN_LONG) begin
            nxt_sdo = rd_ff[3'h7 - cnt_ff[2:0]];
         end else begin
            nxt_sdo = 1'b0;
         end
      end else if (frame_end) begin
         if (cnt_ff == HSW_LEN_SHORT && wr_data != 8'h00) begin
            nxt_chan.output_switch_reg = wr_data[3:0];
         end else if (cnt_ff == HSW_LEN_LONG &&
                      rx_ff[8+HSW_OPC_HI:8+HSW_OPC_LO] == HSW_OPC_WRITE) begin
            if (rx_ff[13:8] == HSW_ADDR_MODE_CTL) begin
               nxt_ctl.unlock            = wr_data[HSW_BIT_UNLOCK];
               nxt_ctl.case_threshold_hi = wr_data[HSW_BIT_TH_HI];
               nxt_ctl.case_threshold_lo = wr_data[HSW_BIT_TH_LO];
               nxt_ctl.standby_request = wr_data[HSW_BIT_STBY] & ctl_ff.unlock;
               nxt_ctl.enable          = wr_data[HSW_BIT_EN] & ctl_ff.unlock;
            end else if (rx_ff[13:8] == HSW_ADDR_DIRECT_EN) begin
               nxt_chan.direct_path_enable_reg = wr_data[3:0];
            end else if (rx_ff[13:8] == HSW_ADDR_PULLUP) begin
               nxt_chan.off_pullup_enable_reg = wr_data[3:0];
            end else if (rx_ff[13:8] == HSW_ADDR_LOAD_TYPE) begin
               nxt_chan.load_type_reg = wr_data[1:0];
            end else if (rx_ff[13:8] == HSW_ADDR_SLOPE) begin
               nxt_chan.slope_select_reg = wr_data[3:0];
            end else if (rx_ff[13:8] == HSW_ADDR_OUT_SW) begin
               nxt_chan.output_switch_reg = wr_data[3:0];
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sck_d_ff <= 1'b0;
         cs_d_ff  <= 1'b1;
         rx_ff    <= 16'h0000;
         cnt_ff   <= 5'h00;
         rd_ff    <= 8'h00;
         sdo_ff   <= 1'b0;
         oe_n_ff  <= 1'b1;
         ctl_ff   <= hsw_ctl_type'({HSW_RST_MODE_CTL[5:4], HSW_RST_MODE_CTL[2:0]});
         chan_ff  <= hsw_chan_type'({HSW_RST_CHAN, HSW_RST_CHAN, HSW_RST_LOAD_TYPE,
                                     HSW_RST_CHAN, HSW_RST_CHAN});
      end else begin
         sck_d_ff <= nxt_sck_d;
         cs_d_ff  <= nxt_cs_d;
         rx_ff    <= nxt_rx;
         cnt_ff   <= nxt_cnt;
         rd_ff    <= nxt_rd;
         sdo_ff   <= nxt_sdo;
         oe_n_ff  <= nxt_oe_n;
         ctl_ff   <= nxt_ctl;
         chan_ff  <= nxt_chan;
      end
   end

   // -----------------------------------------------------------------
   // operating mode and channel outputs
   // -----------------------------------------------------------------
   hsw_mode_type mode_ff,   nxt_mode;
   logic [3:0]   on_ff,     nxt_on;
   logic [1:0]   led_ff,    nxt_led;
   logic [3:0]   fast_ff,   nxt_fast;
   logic [3:0]   pull_ff,   nxt_pull;
   logic [1:0]   th_ff,     nxt_th;

   always_comb begin
      if (ctl_ff.enable && !ctl_ff.standby_request) begin
         nxt_mode = HSW_NORMAL;
      end else if (ctl_ff.standby_request && !ctl_ff.enable) begin
         nxt_mode = HSW_STANDBY;
      end else begin
         nxt_mode = HSW_FAILSAFE;
      end
      case (mode_ff)
         HSW_NORMAL: begin
            nxt_on = chan_ff.output_switch_reg |
                     (chan_ff.direct_path_enable_reg & din_s);
         end
         default: begin
            nxt_on = din_s;
         end
      endcase
      nxt_led  = chan_ff.load_type_reg;
      nxt_fast = chan_ff.slope_select_reg;
      nxt_pull = chan_ff.off_pullup_enable_reg;
      if (ctl_ff.case_threshold_hi) begin
         nxt_th = HSW_TH_140;
      end else if (ctl_ff.case_threshold_lo) begin
         nxt_th = HSW_TH_130;
      end else begin
         nxt_th = HSW_TH_120;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mode_ff <= HSW_FAILSAFE;
         on_ff   <= 4'h0;
         led_ff  <= 2'h0;
         fast_ff <= 4'h0;
         pull_ff <= 4'h0;
         th_ff   <= 2'h0;
      end else begin
         mode_ff <= nxt_mode;
         on_ff   <= nxt_on;
         led_ff  <= nxt_led;
         fast_ff <= nxt_fast;
         pull_ff <= nxt_pull;
         th_ff   <= nxt_th;
      end
   end

   assign sdo_o            = sdo_ff;
   assign sdo_oe_n_o       = oe_n_ff;
   assign chan_on_o        = on_ff;
   assign led_mode_o       = led_ff;
   assign fast_slope_o     = fast_ff;
   assign pullup_en_o      = pull_ff;
   assign case_threshold_o = th_ff;
   assign mode_o           = mode_ff;

endmodule : hsw_output_ctrl

// ---- hsw_output_ctrl_chk.sv ----
`timescale 1ns/100ps
module hsw_output_ctrl_chk
   import hsw_pkg::*;
(
   input wire logic         mclk_i,
   input wire logic         rst_i,
   input wire logic         cs_n_i,
   input wire logic [3:0]   direct_input_pin_i,
   input wire logic         sdo_oe_n_o,
   input wire logic [3:0]   chan_on_o,
   input wire logic [1:0]   led_mode_o,
   input wire logic [3:0]   fast_slope_o,
   input wire logic [3:0]   pullup_en_o,
   input wire logic [1:0]   case_threshold_o,
   input wire hsw_mode_type mode_o
);
   // ------------
   // port checks
   // ------------
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   chk_reset_mode: assert property ($fell(rst_i) |-> mode_o == HSW_FAILSAFE && sdo_oe_n_o)
      else $error("mode or sdo enable wrong after reset");
   chk_reset_outs: assert property ($fell(rst_i) |->
      {chan_on_o, led_mode_o, fast_slope_o, pullup_en_o, case_threshold_o} == 16'h0000)
      else $error("outputs not cleared by reset");
   chk_direct_pins: assert property (
      ($stable(direct_input_pin_i) && mode_o != HSW_NORMAL)[*5]
      |-> chan_on_o == direct_input_pin_i)
      else $error("channels do not follow pins");
   chk_mode_quiet: assert property ($changed(mode_o) |-> $past(cs_n_i) && $past(cs_n_i, 2))
      else $error("mode changed outside a frame end");
   chk_cfg_quiet: assert property (
      $changed({led_mode_o, fast_slope_o, pullup_en_o, case_threshold_o})
      |-> $past(cs_n_i) && $past(cs_n_i, 2))
      else $error("configuration changed outside a frame end");
   chk_oe_release: assert property (cs_n_i[*4] |-> sdo_oe_n_o)
      else $error("sdo still driven while deselected");
   chk_oe_drive: assert property ((!cs_n_i)[*4] |-> !sdo_oe_n_o)
      else $error("sdo not driven while selected");
   chk_normal_steady: assert property (
      (mode_o == HSW_NORMAL && cs_n_i && $stable(direct_input_pin_i))[*8] |-> $stable(chan_on_o))
      else $error("channels moved without cause");
   chk_thresh_code: assert property (case_threshold_o != 2'h3)
      else $error("threshold code out of range");

   cover property (mode_o == HSW_NORMAL && chan_on_o != 4'h0);
   cover property (mode_o == HSW_STANDBY);
   cover property (case_threshold_o == HSW_TH_140);
endmodule : hsw_output_ctrl_chk

// ---- hsw_spi_host.sv ----
`timescale 1ns/100ps
module hsw_spi_host (
   input  wire logic mclk_i,
   input  wire logic sdo_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      sdi_o
);
   // ------------
   // link master
   // ------------
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // half a link clock period
   task automatic half;
      repeat (20) @(negedge mclk_i);
   endtask : half

   // msb first: opcode and address then data, or data only
   task automatic xfer(input int nbits, input logic [15:0] d, output logic [15:0] q);
      q = 16'h0000;
      cs_n_o = 1'b0;
      half();
      for (int i = nbits - 1; i >= 0; i--) begin
         sdi_o = d[i];
         half();
         sck_o = 1'b1;
         q = {q[14:0], sdo_i};
         half();
         sck_o = 1'b0;
      end
      half();
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      half();
   endtask : xfer
endmodule : hsw_spi_host

// ---- hsw_output_ctrl_test.sv ----
`timescale 1ns/100ps
module hsw_output_ctrl_test
   import hsw_pkg::*;
;
   logic         mclk_i, rst_i, sck_i, cs_n_i, sdi_i, sdo_o, sdo_oe_n_o;
   logic [3:0]   direct_input_pin_i, chan_on_o, fast_slope_o, pullup_en_o;
   logic [1:0]   led_mode_o, case_threshold_o;
   hsw_mode_type mode_o;
   logic [15:0]  exp_q[$], obs_q[$], rd;
   string        nm_q[$];
   logic [7:0]   rnd;
   logic [5:0]   addr[6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07};
   int           num_errors = 0;
   int           compares = 0;

   hsw_output_ctrl hsw_output_ctrl_inst (.mclk_i, .rst_i, .sck_i, .cs_n_i, .sdi_i,
      .direct_input_pin_i, .sdo_o, .sdo_oe_n_o, .chan_on_o, .led_mode_o, .fast_slope_o,
      .pullup_en_o, .case_threshold_o, .mode_o);
   // a released data line reads back inverted, so late or missing drive shows up
   hsw_spi_host hsw_spi_host_inst (.mclk_i, .sdo_i(sdo_oe_n_o ? ~sdo_o : sdo_o),
      .sck_o(sck_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));

   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // -------------
   // bench tasks
   // -------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic note(input string nm, input logic [15:0] e, input logic [15:0] o);
      nm_q.push_back(nm);
      exp_q.push_back(e);
      obs_q.push_back(o);
   endtask : note

   task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] o);
      compares++;
      if (o !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, o);
      end
   endtask : cmp_val

   initial forever begin
      @(negedge mclk_i);
      while (obs_q.size() != 0)
         cmp_val(nm_q.pop_front(), exp_q.pop_front(), obs_q.pop_front());
   end

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      hsw_spi_host_inst.xfer(16, {HSW_OPC_WRITE, a, d}, rd);
      repeat (8) @(negedge mclk_i);
   endtask : wr

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      hsw_spi_host_inst.xfer(16, {2'h1, a, 8'h00}, rd);
      note("read data", {HSW_STATUS_BYTE, e}, rd);
   endtask : rd_chk

   task automatic outs(input logic [3:0] ch, input hsw_mode_type m);
      note("channels", {12'h000, ch}, {12'h000, chan_on_o});
      note("mode", {13'h0000, m}, {13'h0000, mode_o});
   endtask : outs

   task automatic pins(input logic [3:0] sw, input logic [3:0] den, input hsw_mode_type m);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         direct_input_pin_i = rnd[3:0];
         repeat (5) @(negedge mclk_i);
         outs((m == HSW_NORMAL) ? (sw | (den & rnd[3:0])) : rnd[3:0], m);
      end
   endtask : pins

   task automatic reset_chk;
      direct_input_pin_i = 4'h0;
      rst_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      outs(4'h0, HSW_FAILSAFE);
      foreach (addr[i]) rd_chk(addr[i], 8'h00);
      $display("test reset done");
   endtask : reset_chk

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // -------------
   // main sequence
   // -------------
   initial begin
      rnd = 8'h61;
      reset_chk();
      wr(6'h05, 8'hff);
      rd_chk(6'h05, 8'h00);
      hsw_spi_host_inst.xfer(16, {2'h2, 6'h04, 8'h0f}, rd);
      rd_chk(6'h04, 8'h00);
      pins(4'h0, 4'h0, HSW_FAILSAFE);
      wr(6'h00, 8'h21);
      rd_chk(6'h00, 8'h00);
      outs(rnd[3:0], HSW_FAILSAFE);
      $display("test lock done");
      for (int t = 0; t < 4; t++) begin
         wr(6'h00, 8'(t << 1));
         note("threshold", (t < 2) ? 16'(t) : 16'h0002, {14'h0000, case_threshold_o});
      end
      rnd = lfsr(rnd);
      for (int a = 2; a < 5; a++) wr(6'(a), rnd);
      note("pullups", {12'h000, rnd[3:0]}, {12'h000, pullup_en_o});
      note("load type", {14'h0000, rnd[1:0]}, {14'h0000, led_mode_o});
      note("slopes", {12'h000, rnd[3:0]}, {12'h000, fast_slope_o});
      rd_chk(6'h03, {6'h00, rnd[1:0]});
      $display("test config done");
      wr(6'h00, 8'h10);
      wr(6'h00, 8'h11);
      wr(6'h01, 8'h05);
      hsw_spi_host_inst.xfer(8, 16'h0003, rd);
      pins(4'h3, 4'h5, HSW_NORMAL);
      hsw_spi_host_inst.xfer(8, 16'h0000, rd);
      rd_chk(6'h07, 8'h03);
      wr(6'h07, rd[7:0] | 8'h08);
      pins(4'hb, 4'h5, HSW_NORMAL);
      $display("test normal done");
      wr(6'h00, 8'h10);
      wr(6'h00, 8'h30);
      pins(4'h0, 4'h0, HSW_STANDBY);
      wr(6'h00, 8'h00);
      pins(4'h0, 4'h0, HSW_FAILSAFE);
      $display("test standby done");
      reset_chk();
      repeat (2) @(negedge mclk_i);
      complete_run();
   end

   initial begin
      repeat (90000) @(posedge mclk_i);
      num_errors++;
      complete_run();
   end
endmodule : hsw_output_ctrl_test

bind hsw_output_ctrl hsw_output_ctrl_chk hsw_output_ctrl_chk_inst (.mclk_i, .rst_i, .cs_n_i,
   .direct_input_pin_i, .sdo_oe_n_o, .chan_on_o, .led_mode_o, .fast_slope_o,
   .pullup_en_o, .case_threshold_o, .mode_o);
